// ### rtl/fscr_regs.sv
// Status two and persistent config one registers behind the serial command port
`timescale 1ns/1ns
`include "fscr_defs.svh"
`default_nettype none

module fscr_regs #(
    parameter int NV_WRITE_CYC = `FSCR_NVW_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic link_sck,
    input wire logic link_cs_n,
    input wire logic link_mosi,
    output logic link_miso,
    output logic link_miso_oe_n,
    input wire logic write_permit_latch,
    output logic reg_write_done,
    output logic nv_write_busy,
    input wire logic erase_check_done,
    input wire logic erase_check_ok,
    input wire logic erase_suspended,
    input wire logic program_suspended,
    input wire logic uniform_sectors,
    input wire logic four_wire_cmd_mode,
    input wire logic four_wire_persist_set,
    input wire logic lock_active,
    input wire logic range_reload,
    input wire logic check_valid,
    input wire fscr_pkg::fscr_blk_t check_block,
    output logic check_reject,
    output logic [2:0] protect_range_bits,
    output logic protect_from_low_sel,
    output logic param_sectors_high_sel,
    output logic wide4_default,
    output logic [7:0] config_one_persistent,
    output logic [7:0] status_two_live
);

    localparam int BW = $clog2(NV_WRITE_CYC + 1);

    // ---------------- Link side, clocked by the serial clock ----------------
    logic [5:0] bit_cnt_reg;
    logic [30:0] shift_reg;
    logic [31:0] frame_word;
    logic [23:0] rd_addr_reg;
    fscr_pkg::fscr_cmd_e op_reg;
    fscr_pkg::fscr_cmd_e op_next;
    fscr_pkg::fscr_cmd_e hold_cmd_reg;
    logic [31:0] hold_word_reg;
    logic req_tog_reg;
    logic [7:0] s2_meta_reg, s2_sync_reg;
    logic [7:0] c1_meta_reg, c1_sync_reg;
    logic [7:0] rd_byte;
    logic rd_phase;
    logic miso_reg;

    assign frame_word = {shift_reg, link_mosi};

    // Opcode decode; unknown codes fall to none and the frame is ignored
    always_comb begin
        unique case (frame_word[7:0])
            `FSCR_OP_RDS2: op_next = fscr_pkg::FSCR_CMD_RDS2;
            `FSCR_OP_READ_ANY_REG_CMD: op_next = fscr_pkg::FSCR_CMD_READ_ANY_REG_CMD;
            `FSCR_OP_WRR: op_next = fscr_pkg::FSCR_CMD_WRR;
            `FSCR_OP_WRITE_ANY_REG_CMD: op_next = fscr_pkg::FSCR_CMD_WRITE_ANY_REG_CMD;
            default: op_next = fscr_pkg::FSCR_CMD_NONE;
        endcase
    end

    // Bit counter; chip select high clears it, so no clock is needed after a frame
    always_ff @(posedge link_sck or posedge link_cs_n) begin
        if (link_cs_n) begin
            bit_cnt_reg <= 6'h00;
        end else if (bit_cnt_reg == `FSCR_CNT_WRAP) begin
            bit_cnt_reg <= `FSCR_CNT_REST; // Read streams repeat the same byte
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
    end

    // Serial input shifter
    always_ff @(posedge link_sck or posedge link_cs_n) begin
        if (link_cs_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= frame_word[30:0];
        end
    end

    // Opcode and read address capture
    always_ff @(posedge link_sck or posedge link_cs_n) begin
        if (link_cs_n) begin
            op_reg <= fscr_pkg::FSCR_CMD_NONE;
            rd_addr_reg <= 24'h000000;
        end else begin
            if (bit_cnt_reg == `FSCR_CNT_OP) begin
                op_reg <= op_next;
            end
            if (bit_cnt_reg == `FSCR_CNT_ADR) begin
                rd_addr_reg <= frame_word[23:0];
            end
        end
    end

    // Completed write frame: hold words, then flip the toggle. A short frame
    // never toggles, so a write-registers with fewer than 16 data bits is dropped.
    // Cleared by srst while the serial clock is idle; an unknown toggle would
    // never settle in the crossing
    always_ff @(posedge link_sck or posedge srst) begin
        if (srst) begin
            hold_cmd_reg <= fscr_pkg::FSCR_CMD_NONE;
            hold_word_reg <= 32'h00000000;
            req_tog_reg <= 1'b0;
        end else if (!link_cs_n && op_reg == fscr_pkg::FSCR_CMD_WRR &&
                bit_cnt_reg == `FSCR_CNT_WRR) begin
            hold_cmd_reg <= op_reg;
            hold_word_reg <= frame_word;
            req_tog_reg <= ~req_tog_reg;
        end else if (!link_cs_n && op_reg == fscr_pkg::FSCR_CMD_WRITE_ANY_REG_CMD &&
                bit_cnt_reg == `FSCR_CNT_WRITE_ANY_REG_CMD) begin
            hold_cmd_reg <= op_reg;
            hold_word_reg <= frame_word;
            req_tog_reg <= ~req_tog_reg;
        end
    end

    // Register values enter the link domain as two-flop levels; they change rarely
    always_ff @(posedge link_sck) begin
        s2_meta_reg <= status_two_live;
        s2_sync_reg <= s2_meta_reg;
        c1_meta_reg <= config_one_persistent;
        c1_sync_reg <= c1_meta_reg;
    end

    // Read byte select; unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_phase = 1'b0;
        if (op_reg == fscr_pkg::FSCR_CMD_RDS2 && bit_cnt_reg >= `FSCR_HDR_S2) begin
            rd_byte = s2_sync_reg;
            rd_phase = 1'b1;
        end else if (op_reg == fscr_pkg::FSCR_CMD_READ_ANY_REG_CMD && bit_cnt_reg >= `FSCR_HDR_AR) begin
            rd_phase = 1'b1;
            if (rd_addr_reg == `FSCR_ADDR_S2) begin
                rd_byte = s2_sync_reg;
            end else if (rd_addr_reg == `FSCR_ADDR_C1) begin
                rd_byte = c1_sync_reg;
            end
        end
    end

    // Output bit changes on the falling edge, MSB first
    always_ff @(negedge link_sck or posedge link_cs_n) begin
        if (link_cs_n) begin
            miso_reg <= 1'b0;
        end else begin
            miso_reg <= rd_byte[3'h7 - bit_cnt_reg[2:0]];
        end
    end

    assign link_miso = miso_reg;
    assign link_miso_oe_n = ~(rd_phase && !link_cs_n);

    // ---------------- Register side, clocked by the system clock ------------
    logic tog_meta_reg, tog_sync_reg, tog_seen_reg;
    logic wr_strobe, wr_ok, is_wrr, is_c1;
    logic cfg_wr, bp_wr, bpv_rise, nv_start;
    logic [7:0] cfg_reg, cfg_next;
    logic [2:0] bp_live_reg, persistent_protect_range_reg, bp_new;
    logic [BW-1:0] busy_cnt_reg;
    logic est_reg, esus_reg, psus_reg;
    logic done_reg, reject_reg;
    logic [6:0] prot_n;
    logic hit;

    // Toggle crossing; the first flop is never looked at, the edge comes from the second and third
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_meta_reg <= req_tog_reg;
            tog_sync_reg <= tog_meta_reg;
            tog_seen_reg <= tog_sync_reg;
        end
    end

    assign wr_strobe = tog_sync_reg ^ tog_seen_reg;
    // Writes need the permit latch and an idle persistent write
    assign wr_ok = wr_strobe && write_permit_latch && !nv_write_busy;
    assign is_wrr = hold_cmd_reg == fscr_pkg::FSCR_CMD_WRR;
    assign is_c1 = hold_cmd_reg == fscr_pkg::FSCR_CMD_WRITE_ANY_REG_CMD &&
        hold_word_reg[31:8] == `FSCR_ADDR_C1;
    // Writes to the status two address are accepted but change nothing
    assign cfg_wr = wr_ok && (is_wrr || is_c1);
    assign bp_wr = wr_ok && is_wrr && !lock_active;
    assign bp_new = hold_word_reg[8 + `FSCR_BP_MSB:8 + `FSCR_BP_LSB];

    // Config merge: one-time bits only OR in, lock freezes them, bit 0 and
    // reserved bits never take host data
    always_comb begin
        cfg_next = cfg_reg & `FSCR_C1_OTP_MASK;
        if (!lock_active) begin
            cfg_next = (cfg_reg | hold_word_reg[7:0]) & `FSCR_C1_OTP_MASK;
        end
        cfg_next[`FSCR_C1_WIDE4] = hold_word_reg[`FSCR_C1_WIDE4];
        if (four_wire_cmd_mode && cfg_reg[`FSCR_C1_WIDE4]) begin
            cfg_next[`FSCR_C1_WIDE4] = 1'b1;
        end
        cfg_next[`FSCR_C1_FRZ] = cfg_reg[`FSCR_C1_FRZ];
    end

    assign bpv_rise = cfg_wr && cfg_next[`FSCR_C1_BPV] && !cfg_reg[`FSCR_C1_BPV];

    // Persistent config register; shipped value is all zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_reg <= `FSCR_C1_RESET;
        end else begin
            if (cfg_wr) begin
                cfg_reg <= cfg_next;
            end
            if (four_wire_persist_set) begin
                cfg_reg[`FSCR_C1_WIDE4] <= 1'b1;
            end
        end
    end

    // Protection range copies. Persistent copy is written only while the
    // volatility bit is 0; setting that bit forces it to all ones.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            persistent_protect_range_reg <= `FSCR_BP_RESET;
            bp_live_reg <= `FSCR_BP_RESET;
        end else begin
            if (range_reload) begin
                bp_live_reg <= persistent_protect_range_reg;
            end
            if (bp_wr) begin
                bp_live_reg <= bp_new;
                if (!cfg_reg[`FSCR_C1_BPV]) begin
                    persistent_protect_range_reg <= bp_new;
                end
            end
            if (bpv_rise) begin
                persistent_protect_range_reg <= `FSCR_BP_ALL;
            end
        end
    end

    // Persistent writes hold busy for the write time; live-only writes do not
    assign nv_start = (cfg_wr && cfg_next != cfg_reg) ||
        (bp_wr && !cfg_reg[`FSCR_C1_BPV]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_cnt_reg <= '0;
        end else if (nv_start) begin
            busy_cnt_reg <= BW'(NV_WRITE_CYC);
        end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - BW'(1);
        end
    end

    assign nv_write_busy = busy_cnt_reg != '0;

    // One-cycle completion pulse so the permit latch can be cleared outside
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= wr_ok;
        end
    end

    assign reg_write_done = done_reg;

    // Status two: hardware-owned, the host has no path into these flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            est_reg <= 1'b0;
            esus_reg <= 1'b0;
            psus_reg <= 1'b0;
        end else begin
            if (erase_check_done) begin
                est_reg <= erase_check_ok;
            end
            esus_reg <= erase_suspended;
            psus_reg <= program_suspended;
        end
    end

    // Result is shown as 0 while suspended since it cannot be trusted then
    always_comb begin
        status_two_live = `FSCR_S2_RESET;
        status_two_live[`FSCR_S2_EST] = est_reg && !esus_reg && !psus_reg;
        status_two_live[`FSCR_S2_ESUS] = esus_reg;
        status_two_live[`FSCR_S2_PSUS] = psus_reg;
    end

    // Decoded views of the configuration
    assign config_one_persistent = cfg_reg;
    assign protect_from_low_sel = cfg_reg[`FSCR_C1_LOW];
    assign param_sectors_high_sel = cfg_reg[`FSCR_C1_PARM] && !uniform_sectors;
    assign wide4_default = cfg_reg[`FSCR_C1_WIDE4];
    assign protect_range_bits = cfg_reg[`FSCR_C1_BPV] ? bp_live_reg : persistent_protect_range_reg;

    // Protected span: 1/64 doubling per step, all ones covers the whole array
    always_comb begin
        prot_n = 7'h00;
        if (protect_range_bits == `FSCR_BP_ALL) begin
            prot_n = `FSCR_BLK_COUNT;
        end else if (protect_range_bits != `FSCR_BP_RESET) begin
            prot_n = 7'h01 << (protect_range_bits - 3'h1);
        end
        if (protect_from_low_sel) begin
            hit = {1'b0, check_block} < prot_n;
        end else begin
            hit = {1'b0, check_block} >= (`FSCR_BLK_COUNT - prot_n);
        end
        hit = hit && (prot_n != 7'h00);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reject_reg <= 1'b0;
        end else begin
            reject_reg <= check_valid && hit;
        end
    end

    assign check_reject = reject_reg;

    // ---------------- Checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_check_seen;
        erase_check_done && !erase_suspended && !program_suspended;
    endsequence
    sequence s_clean;
        !erase_suspended && !program_suspended && !erase_check_done;
    endsequence

    property p_erase_result;
        s_check_seen ##1 s_clean |=> status_two_live[`FSCR_S2_EST] == $past(erase_check_ok, 2);
    endproperty
    a_erase_result: assert property (p_erase_result) else $error("erase result wrong");

    property p_susp_hide;
        (esus_reg || psus_reg) |-> !status_two_live[`FSCR_S2_EST];
    endproperty
    a_susp_hide: assert property (p_susp_hide) else $error("result shown in suspend");

    property p_esus;
        erase_suspended |=> status_two_live[`FSCR_S2_ESUS];
    endproperty
    a_esus: assert property (p_esus) else $error("erase suspend not shown");

    property p_psus;
        !program_suspended |=> !status_two_live[`FSCR_S2_PSUS];
    endproperty
    a_psus: assert property (p_psus) else $error("program suspend shown idle");

    property p_otp_sticky;
        $past(srst) || ($past(cfg_reg) & ~cfg_reg & `FSCR_C1_OTP_MASK) == 8'h00;
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("one-time bit fell");

    property p_bpv_forces_all;
        bpv_rise |=> persistent_protect_range_reg == `FSCR_BP_ALL;
    endproperty
    a_bpv_forces_all: assert property (p_bpv_forces_all) else $error("range not all ones");

    property p_live_fast;
        bp_wr && cfg_reg[`FSCR_C1_BPV] && cfg_next == cfg_reg |=>
            !nv_write_busy && $stable(persistent_protect_range_reg);
    endproperty
    a_live_fast: assert property (p_live_fast) else $error("live write touched nv");

    property p_wide4_keep;
        four_wire_cmd_mode && wide4_default |=> wide4_default;
    endproperty
    a_wide4_keep: assert property (p_wide4_keep) else $error("wide4 cleared in mode");

    property p_wide4_set;
        four_wire_persist_set |=> wide4_default;
    endproperty
    a_wide4_set: assert property (p_wide4_set) else $error("wide4 not programmed");

    property p_ro_bits;
        (cfg_reg & 8'hD1) == 8'h00 && status_two_live[7:3] == 5'h00;
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("reserved or lock bit set");

    property p_uniform;
        uniform_sectors |-> !param_sectors_high_sel;
    endproperty
    a_uniform: assert property (p_uniform) else $error("parameter bit active");

endmodule // fscr_regs
`default_nettype wire

// ### rtl/fscr_defs.svh
// Constants for the erase-suspend status and persistent config one registers
`ifndef FSCR_DEFS_SVH
`define FSCR_DEFS_SVH
`define FSCR_OP_RDS2 8'h07
`define FSCR_OP_READ_ANY_REG_CMD 8'h65
`define FSCR_OP_WRR 8'h01
`define FSCR_OP_WRITE_ANY_REG_CMD 8'h71
`define FSCR_ADDR_S2 24'h000001
`define FSCR_ADDR_C1 24'h000002
`define FSCR_S2_EST 2
`define FSCR_S2_ESUS 1
`define FSCR_S2_PSUS 0
`define FSCR_C1_LOW 5
`define FSCR_C1_BPV 3
`define FSCR_C1_PARM 2
`define FSCR_C1_WIDE4 1
`define FSCR_C1_FRZ 0
`define FSCR_C1_OTP_MASK 8'h2C
`define FSCR_C1_RESET 8'h00
`define FSCR_S2_RESET 8'h00
`define FSCR_BP_MSB 4
`define FSCR_BP_LSB 2
`define FSCR_BP_RESET 3'h0
`define FSCR_BP_ALL 3'h7
`define FSCR_BLK_COUNT 7'h40
`define FSCR_CNT_OP 6'h07
`define FSCR_CNT_ADR 6'h1F
`define FSCR_CNT_WRR 6'h17
`define FSCR_CNT_WRITE_ANY_REG_CMD 6'h27
`define FSCR_HDR_S2 6'h08
`define FSCR_HDR_AR 6'h20
`define FSCR_CNT_WRAP 6'h2F
`define FSCR_CNT_REST 6'h28
`define FSCR_CLK_KHZ 20000
`define FSCR_T_NVW_NS 500000
`define FSCR_NVW_CYC (((`FSCR_T_NVW_NS / 1000) * `FSCR_CLK_KHZ) / 1000)
`endif

// ### rtl/fscr_pkg.sv
// Types shared by the register block
package fscr_pkg;
    typedef enum logic [2:0] {
        FSCR_CMD_NONE,
        FSCR_CMD_RDS2,
        FSCR_CMD_READ_ANY_REG_CMD,
        FSCR_CMD_WRR,
        FSCR_CMD_WRITE_ANY_REG_CMD
    } fscr_cmd_e;
    typedef logic [5:0] fscr_blk_t;
endpackage

// ### tb/fscr_host_model.sv
// Host controller model that sends register frames over the serial link
`timescale 1ns/1ns
`default_nettype none

module fscr_host_model (
    output logic link_sck,
    output logic link_cs_n,
    output logic link_mosi,
    input wire logic link_miso,
    input wire logic link_miso_oe_n
);
    int oe_bad = 0;

    // Link clock stands low and select stays high between frames
    initial begin
        link_sck = 1'b0;
        link_cs_n = 1'b1;
        link_mosi = 1'b0;
    end

    // One frame in mode 0: nout bits out MSB first, then nin bits back
    task automatic frame(input logic [47:0] bits, input int nout, input int nin,
                         output logic [7:0] rd);
        rd = 8'h00;
        #7;
        link_cs_n = 1'b0;
        for (int i = 0; i < nout + nin; i++) begin
            if (i < nout) begin
                link_mosi = bits[nout-1-i];
            end else begin
                link_mosi = ~link_mosi; // Toggle once our data is over, never a stale level
            end
            #15;
            link_sck = 1'b1;
            // Output enable low exactly while read data is due
            if (link_miso_oe_n !== (i < nout)) oe_bad++;
            if (i >= nout) begin
                rd = {rd[6:0], link_miso};
            end
            #15;
            link_sck = 1'b0;
        end
        #15;
        link_cs_n = 1'b1;
        link_mosi = ~link_mosi;
        #400; // Spacing between frames so the sync stage settles
    endtask
endmodule // fscr_host_model

`default_nettype wire

// ### tb/fscr_regs_tb_top.sv
// Self-checking bench for the status two and persistent config one registers
`timescale 1ns/1ns
`include "fscr_defs.svh"
`default_nettype none

module fscr_regs_tb_top;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    wire link_sck, link_cs_n, link_mosi;
    logic link_miso, link_miso_oe_n, reg_write_done, nv_write_busy, check_reject;
    logic write_permit_latch = 1'b0, erase_check_done = 1'b0, erase_check_ok = 1'b0;
    logic erase_suspended = 1'b0, program_suspended = 1'b0, uniform_sectors = 1'b0;
    logic four_wire_cmd_mode = 1'b0, four_wire_persist_set = 1'b0, lock_active = 1'b0;
    logic range_reload = 1'b0, check_valid = 1'b0;
    fscr_pkg::fscr_blk_t check_block = 6'h00;
    logic [2:0] protect_range_bits;
    logic protect_from_low_sel, param_sectors_high_sel, wide4_default;
    logic [7:0] config_one_persistent, status_two_live, rd;
    logic [7:0] m_cfg = 8'h00;
    logic [2:0] m_nv = 3'h0;
    logic [2:0] m_live = 3'h0;
    logic m_ok = 1'b0;
    localparam int NVW = 8;
    int n_done = 0;
    int n_busy = 0;
    logic [31:0] seed = 32'h7B9782AB;
    logic [31:0] v;
    int n_errors = 0;
    int checks = 0;

    always #25 sys_clk = ~sys_clk;

    // Done pulses and busy cycles are counted here; the done pulse comes before a frame returns, busy cycles can run past it
    always @(posedge sys_clk) begin
        if (reg_write_done === 1'b1) n_done++;
        if (nv_write_busy === 1'b1) n_busy++;
    end

    // Short persistent write time keeps the run brief
    fscr_regs #(.NV_WRITE_CYC(NVW)) u_dut (.sys_clk(sys_clk), .srst(srst), .link_sck(link_sck),
        .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
        .link_miso_oe_n(link_miso_oe_n), .write_permit_latch(write_permit_latch),
        .reg_write_done(reg_write_done), .nv_write_busy(nv_write_busy),
        .erase_check_done(erase_check_done), .erase_check_ok(erase_check_ok),
        .erase_suspended(erase_suspended), .program_suspended(program_suspended),
        .uniform_sectors(uniform_sectors), .four_wire_cmd_mode(four_wire_cmd_mode),
        .four_wire_persist_set(four_wire_persist_set), .lock_active(lock_active),
        .range_reload(range_reload), .check_valid(check_valid), .check_block(check_block),
        .check_reject(check_reject), .protect_range_bits(protect_range_bits),
        .protect_from_low_sel(protect_from_low_sel),
        .param_sectors_high_sel(param_sectors_high_sel), .wide4_default(wide4_default),
        .config_one_persistent(config_one_persistent), .status_two_live(status_two_live));

    fscr_host_model u_host (.link_sck(link_sck), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
        .link_miso(link_miso), .link_miso_oe_n(link_miso_oe_n));

    // Xorshift source for stimulus
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Range that currently guards the array
    function automatic logic [2:0] sel();
        return m_cfg[3] ? m_live : m_nv;
    endfunction

    // Config byte after a write: one-time bits only ever set, bit 0 and spares never follow
    function automatic logic [7:0] nxt_cfg(input logic [7:0] o, input logic [7:0] w);
        logic [7:0] n;
        n = o;
        if (!lock_active) begin
            n = n | (w & `FSCR_C1_OTP_MASK);
        end
        n[1] = w[1] | (o[1] & four_wire_cmd_mode);
        return n;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Level inputs: suspends, permit, lock, four-wire mode, uniform map
    task automatic lv(input logic [5:0] x);
        @(posedge sys_clk);
        {erase_suspended, program_suspended, write_permit_latch, lock_active,
            four_wire_cmd_mode, uniform_sectors} <= x;
        cyc(4);
    endtask

    // One-cycle strobe, mirrored in the model
    task automatic pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) begin
            erase_check_done <= 1'b1;
        end else if (which == 1) begin
            range_reload <= 1'b1;
        end else begin
            four_wire_persist_set <= 1'b1;
        end
        erase_check_ok <= m_ok;
        @(posedge sys_clk);
        {erase_check_done, range_reload, four_wire_persist_set} <= 3'h0;
        if (which == 1) m_live = m_nv; // Reload of the live range
        if (which == 2) m_cfg[1] = 1'b1; // Persistent four-wire pick sets wide4
        cyc(20);
    endtask

    // Status two through both read commands
    task automatic rd_s2();
        logic [7:0] e;
        e = {5'h00, m_ok & ~erase_suspended & ~program_suspended, erase_suspended,
            program_suspended};
        u_host.frame({40'h0, `FSCR_OP_RDS2}, 8, 8, rd);
        chk(rd, e);
        u_host.frame({16'h0, `FSCR_OP_READ_ANY_REG_CMD, `FSCR_ADDR_S2}, 32, 8, rd);
        chk(rd, e);
        chk(status_two_live, e);
        chk(8'(u_host.oe_bad), 8'h00);
    endtask

    // Config one through read-any and at the decoded outputs
    task automatic rd_cfg();
        logic [7:0] e;
        e = {5'h00, m_cfg[5], m_cfg[2] & ~uniform_sectors, m_cfg[1]};
        u_host.frame({16'h0, `FSCR_OP_READ_ANY_REG_CMD, `FSCR_ADDR_C1}, 32, 8, rd);
        chk(rd, m_cfg);
        chk(config_one_persistent, m_cfg);
        chk({5'h00, protect_range_bits}, {5'h00, sel()});
        chk({5'h00, protect_from_low_sel, param_sectors_high_sel, wide4_default},
            e);
    endtask

    // Write frame (0 write-regs, 1 write-any to config, 2 write-any to status two)
    task automatic wr(input int md, input logic [2:0] r, input logic [7:0] w);
        logic [7:0] o;
        logic [2:0] onv;
        logic eb;
        int d0;
        int b0;
        o = m_cfg;
        onv = m_nv;
        d0 = n_done;
        b0 = n_busy;
        if (md == 0) begin
            u_host.frame({24'h0, `FSCR_OP_WRR, 3'h0, r, 2'h0, w}, 24, 0, rd);
        end else begin
            u_host.frame({8'h00, `FSCR_OP_WRITE_ANY_REG_CMD, md == 1 ? `FSCR_ADDR_C1 : `FSCR_ADDR_S2, w},
                40, 0, rd);
        end
        if (write_permit_latch && md != 2) begin
            m_cfg = nxt_cfg(o, w);
            if (md == 0 && !lock_active) begin
                m_live = r;
                if (!o[3]) m_nv = r;
            end
            if (m_cfg[3] && !o[3]) m_nv = `FSCR_BP_ALL;
        end
        // Any unlocked range write in persistent mode takes the slow write time
        eb = write_permit_latch && (m_cfg != o || m_nv != onv ||
            (md == 0 && !lock_active && !o[3]));
        for (int k = 0; k < 40 && nv_write_busy !== 1'b0; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(8'(n_done - d0), {7'h00, write_permit_latch});
        chk(8'(n_busy - b0), eb ? 8'(NVW) : 8'h00);
        if (nv_write_busy !== 1'b0) begin
            n_errors++;
            give_verdict();
        end
    endtask

    // Program/erase block checks against the selected range
    task automatic chk_rej(input int n);
        int b;
        int s;
        logic e;
        for (int k = 0; k < n; k++) begin
            b = int'(xs() % (k[0] ? 64 : 8));
            s = 1 << (sel() - 3'h1);
            e = sel() == 3'h7 || (sel() != 3'h0 && (m_cfg[5] ? b < s : b >= 64 - s));
            @(posedge sys_clk);
            check_valid <= 1'b1;
            check_block <= b[5:0];
            @(posedge sys_clk);
            check_valid <= 1'b0;
            #1;
            chk({7'h00, check_reject}, {7'h00, e});
        end
    endtask

    initial begin
        cyc(10);
        srst <= 1'b0;
        cyc(2);
        rd_cfg();
        rd_s2();
        // Erase check issued right before each status read
        for (int i = 0; i < 8; i++) begin
            v = xs();
            m_ok = v[2] | (i == 0);
            pulse(0);
            lv({v[0] & (i > 1), v[1] & (i > 1), 4'h0});
            rd_s2();
        end
        lv(6'h08);
        wr(2, 3'h0, 8'hFF);
        rd_s2();
        lv(6'h00);
        wr(0, 3'h5, 8'h26);
        rd_cfg();
        lv(6'h08);
        wr(0, 3'h3, 8'h02);
        rd_cfg();
        // One-time location bits chosen apart, before any program or erase
        wr(1, 3'h0, 8'h22);
        rd_cfg();
        wr(1, 3'h0, 8'h06);
        rd_cfg();
        chk_rej(12);
        wr(1, 3'h0, 8'hD1);
        rd_cfg();
        // Lock holds range and one-time bits, wide4 still moves
        lv(6'h0C);
        wr(0, 3'h7, 8'h06);
        rd_cfg();
        lv(6'h08);
        wr(1, 3'h0, 8'h26);
        rd_cfg();
        lv(6'h09);
        rd_cfg();
        lv(6'h0A);
        wr(1, 3'h0, 8'h00);
        rd_cfg();
        lv(6'h08);
        wr(1, 3'h0, 8'h00);
        pulse(2);
        rd_cfg();
        // Volatile range mode: fast live-only writes, reload from persistent copy
        wr(1, 3'h0, 8'h0A);
        pulse(1);
        rd_cfg();
        chk_rej(8);
        wr(0, 3'h2, m_cfg);
        rd_cfg();
        chk_rej(12);
        pulse(1);
        rd_cfg();
        give_verdict();
    end
endmodule // fscr_regs_tb_top

`default_nettype wire
